// file: inc/ppr_pkg.sv
// package of the process regulator: map, fields, reset values, timing
// =====================================================================
// Summary of operation
// - enabling the regulator forces feedback select, input functions, forward only and jog off.
// - with the manual/auto function assigned, a low input means manual and a high one automatic.
// - action 0 is direct (speed up raises the process value), action 1 is reverse.
// - the process value always comes from the analog input named by the feedback selector.
// - the setpoint comes from the keypad percentage or from the first analog input.
// - in automatic the speed follows a PID law on setpoint minus process value, or on process value minus setpoint with action 1.
// - the measured process value is readable as a percentage.
// - the feedback input gets a programmable gain and offset before use.
// - the displayed process value uses a scale factor, decimal point and three unit characters.
// - the four readouts are setpoint, process value, motor speed and displayed value, in that order.
// - the regulator speed demand stays within the minimum and maximum speed limits.
// - going manual to automatic with autocopy on and the keypad as setpoint source loads the keypad setpoint with the process value.
package ppr_pkg;
  // =====================================================================
  // timing
  localparam int CLK_MHZ = 250;
  localparam int PID_PERIOD_US = 1000;
  localparam int PID_PERIOD_CYC = PID_PERIOD_US * CLK_MHZ;
  localparam int GAIN_FRAC = 10;
  // =====================================================================
  // register offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_SETPOINT = 8'h04;
  localparam logic [7:0] ADR_FB_GAIN = 8'h08;
  localparam logic [7:0] ADR_FB_OFFSET = 8'h0C;
  localparam logic [7:0] ADR_KP = 8'h10;
  localparam logic [7:0] ADR_KI = 8'h14;
  localparam logic [7:0] ADR_KD = 8'h18;
  localparam logic [7:0] ADR_SPD_MIN = 8'h1C;
  localparam logic [7:0] ADR_SPD_MAX = 8'h20;
  localparam logic [7:0] ADR_DISP_SCALE = 8'h24;
  localparam logic [7:0] ADR_DISP_FMT = 8'h28;
  localparam logic [7:0] ADR_IO_CFG = 8'h2C;
  localparam logic [7:0] ADR_SP_READ = 8'h30;
  localparam logic [7:0] ADR_PV_READ = 8'h34;
  localparam logic [7:0] ADR_SPD_READ = 8'h38;
  localparam logic [7:0] ADR_DISP_READ = 8'h3C;
  localparam logic [7:0] ADR_STATUS = 8'h40;
  // =====================================================================
  // field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_REV = 1;
  localparam int CTRL_COPY = 2;
  localparam int CTRL_SPSRC = 3;
  localparam int CTRL_FBSEL = 4;
  localparam int IO_FN3 = 8;
  localparam int IO_FWD = 16;
  localparam int IO_JOG = 17;
  localparam int FMT_UNIT = 8;
  // =====================================================================
  // reset and forced values
  localparam logic [1:0] FBSEL_RST = 2'h1;
  localparam logic [15:0] GAIN_RST = 16'h0400;
  localparam logic [15:0] KP_RST = 16'h0400;
  localparam logic [15:0] KI_RST = 16'h0400;
  localparam logic [15:0] SPD_MAX_RST = 16'h0708;
  localparam logic [15:0] SCALE_RST = 16'h03E8;
  localparam logic [1:0] DP_RST = 2'h1;
  localparam logic [7:0] FN2_PROCESS = 8'h03;
  localparam logic [7:0] FN3_MANAUTO = 8'h16;
  localparam logic [25:0] PCT_FULL = 26'h00003E8;
  typedef enum logic [2:0] {ST_OFF = 3'b001, ST_MANUAL = 3'b010, ST_AUTO = 3'b100} ppr_state_e;
  // converter code to tenths of a percent
  function automatic logic [9:0] ppr_pct(input logic [11:0] raw);
    ppr_pct = 10'((22'(raw) * 22'(PCT_FULL)) >> 12);
  endfunction
endpackage

// file: inc/ppr_lim_if.sv
// interface between a limiter and its user
`timescale 1ns/100ps
interface ppr_lim_if;
  logic signed [31:0] value;
  logic [15:0] lo;
  logic [15:0] hi;
  logic [15:0] result;
  logic at_hi;
  logic at_lo;
  modport calc (input value, lo, hi, output result, at_hi, at_lo);
  modport user (output value, lo, hi, input result, at_hi, at_lo);
endinterface

// file: core/ppr_limit.sv
// limiter of a speed demand to a programmable band
`timescale 1ns/100ps
module ppr_limit (
  ppr_lim_if.calc lim
);
  // =====================================================================
  // clamp; if software sets min above max, a value at or above max gives max and any lower value gives min
  always_comb begin
    lim.at_hi = lim.value >= $signed({16'h0000, lim.hi});
    lim.at_lo = lim.value <= $signed({16'h0000, lim.lo});
    if (lim.at_hi) begin
      lim.result = lim.hi;
    end else if (lim.at_lo) begin
      lim.result = lim.lo;
    end else begin
      lim.result = lim.value[15:0];
    end
  end
endmodule // ppr_limit

// file: core/ppr_fbscale.sv
// feedback conditioning: percent, gain, offset, clamp to 0..100.0 %
`timescale 1ns/100ps
module ppr_fbscale (
  input wire logic [11:0] raw_i,
  input wire logic [15:0] gain_i,
  input wire logic [15:0] offset_i,
  output logic [9:0] pct_o
);
  import ppr_pkg::*;
  logic signed [31:0] v;
  // =====================================================================
  // gain has ten fraction bits; offset is signed tenths of a percent
  always_comb begin
    v = $signed(32'({6'h00, ppr_pct(raw_i)} * {10'h000, gain_i}) >> GAIN_FRAC);
    v = v + 32'($signed(offset_i));
    if (v < 0) begin
      pct_o = 10'h000;
    end else if (v > $signed(32'(PCT_FULL))) begin
      pct_o = PCT_FULL[9:0];
    end else begin
      pct_o = v[9:0];
    end
  end
endmodule // ppr_fbscale

// file: core/ppr_top.sv
// process regulator top: wishbone registers, feedback path and pid loop
//
// Added by the designer: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
module ppr_top #(
  parameter int PID_PERIOD = ppr_pkg::PID_PERIOD_CYC
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [3:0][11:0] analog_in_i,
  input wire logic manual_auto_input_i,
  input wire logic [15:0] manual_speed_ref_i,
  output logic [15:0] speed_ref_o,
  output logic auto_mode_o,
  output logic forward_only_o,
  output logic jog_enable_o
);
  import ppr_pkg::*;

  // =====================================================================
  // reset release through two flops
  logic [1:0] rst_q_r;
  logic rst_n;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_q_r <= 2'h0;
    end else begin
      rst_q_r <= {rst_q_r[0], 1'b1};
    end
  end
  assign rst_n = rst_q_r[1];

  // =====================================================================
  // pin synchronisers; only the second stage is read
  logic [3:0][11:0] ain1_r, ain2_r, ain1_nxt, ain2_nxt;
  logic mai1_r, mai2_r, mai1_nxt, mai2_nxt;
  always_comb begin
    ain1_nxt = analog_in_i;
    ain2_nxt = ain1_r;
    mai1_nxt = manual_auto_input_i;
    mai2_nxt = mai1_r;
  end
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ain1_r <= '0;
      ain2_r <= '0;
      mai1_r <= 1'b0;
      mai2_r <= 1'b0;
    end else begin
      ain1_r <= ain1_nxt;
      ain2_r <= ain2_nxt;
      mai1_r <= mai1_nxt;
      mai2_r <= mai2_nxt;
    end
  end

  // =====================================================================
  // register state
  logic en_r, rev_r, copy_r, spsrc_r, fwd_r, jog_r, ack_r;
  logic en_nxt, rev_nxt, copy_nxt, spsrc_nxt, fwd_nxt, jog_nxt, ack_nxt;
  logic [1:0] fbsel_r, fbsel_nxt, dp_r, dp_nxt;
  logic [9:0] spk_r, spk_nxt;
  logic [15:0] gain_r, gain_nxt, offs_r, offs_nxt, kp_r, kp_nxt, ki_r, ki_nxt, kd_r, kd_nxt;
  logic [15:0] min_r, min_nxt, max_r, max_nxt, scale_r, scale_nxt;
  logic [23:0] unit_r, unit_nxt;
  logic [7:0] fn2_r, fn2_nxt, fn3_r, fn3_nxt;
  logic [31:0] rdat_r, rdat_nxt, wv, rv;
  logic req, wr;
  // loop state, declared here for the read mux
  ppr_state_e st_r, st_nxt;
  logic [9:0] pv_r, pv_nxt, sp_r, sp_nxt, pv_now;
  logic [15:0] spd_r, spd_nxt, disp_r, disp_nxt;
  logic to_auto;

  // merge the written lanes into the current register word
  function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] d, input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = s[b] ? d[8*b +: 8] : cur[8*b +: 8];
    end
  endfunction

  // =====================================================================
  // wishbone slave: ack one cycle after the strobe, then drop for a cycle
  always_comb begin
    req = wb_cyc_i && wb_stb_i && !ack_r;
    wr = req && wb_we_i;
    ack_nxt = req;
    {en_nxt, rev_nxt, copy_nxt, spsrc_nxt, fbsel_nxt} = {en_r, rev_r, copy_r, spsrc_r, fbsel_r};
    {spk_nxt, gain_nxt, offs_nxt, kp_nxt, ki_nxt, kd_nxt} = {spk_r, gain_r, offs_r, kp_r, ki_r, kd_r};
    {min_nxt, max_nxt, scale_nxt, dp_nxt, unit_nxt} = {min_r, max_r, scale_r, dp_r, unit_r};
    {fn2_nxt, fn3_nxt, fwd_nxt, jog_nxt} = {fn2_r, fn3_r, fwd_r, jog_r};
    case (wb_adr_i)
      ADR_CTRL: rv = 32'({fbsel_r, spsrc_r, copy_r, rev_r, en_r});
      ADR_SETPOINT: rv = 32'(spk_r);
      ADR_FB_GAIN: rv = 32'(gain_r);
      ADR_FB_OFFSET: rv = 32'(offs_r);
      ADR_KP: rv = 32'(kp_r);
      ADR_KI: rv = 32'(ki_r);
      ADR_KD: rv = 32'(kd_r);
      ADR_SPD_MIN: rv = 32'(min_r);
      ADR_SPD_MAX: rv = 32'(max_r);
      ADR_DISP_SCALE: rv = 32'(scale_r);
      ADR_DISP_FMT: rv = {unit_r, 6'h00, dp_r};
      ADR_IO_CFG: rv = 32'({jog_r, fwd_r, fn3_r, fn2_r});
      ADR_SP_READ: rv = 32'(sp_r);
      ADR_PV_READ: rv = 32'(pv_r);
      ADR_SPD_READ: rv = 32'(spd_r);
      ADR_DISP_READ: rv = 32'(disp_r);
      ADR_STATUS: rv = 32'(st_r);
      default: rv = 32'h0000_0000;
    endcase
    rdat_nxt = req ? rv : 32'h0000_0000;
    wv = merge(rv, wb_dat_i, wb_sel_i);
    if (wr) begin
      case (wb_adr_i)
        ADR_CTRL: begin
          {fbsel_nxt, spsrc_nxt, copy_nxt, rev_nxt, en_nxt} = wv[CTRL_FBSEL+1:CTRL_EN];
        end
        ADR_SETPOINT: spk_nxt = (wv[15:0] > 16'(PCT_FULL)) ? PCT_FULL[9:0] : wv[9:0];
        ADR_FB_GAIN: gain_nxt = wv[15:0];
        ADR_FB_OFFSET: offs_nxt = wv[15:0];
        ADR_KP: kp_nxt = wv[15:0];
        ADR_KI: ki_nxt = wv[15:0];
        ADR_KD: kd_nxt = wv[15:0];
        ADR_SPD_MIN: min_nxt = wv[15:0];
        ADR_SPD_MAX: max_nxt = wv[15:0];
        ADR_DISP_SCALE: scale_nxt = wv[15:0];
        ADR_DISP_FMT: {unit_nxt, dp_nxt} = {wv[31:FMT_UNIT], wv[1:0]};
        ADR_IO_CFG: {jog_nxt, fwd_nxt, fn3_nxt, fn2_nxt} = wv[IO_JOG:0];
        default: ;
      endcase
    end
    // switching the function on rewrites the dependent settings
    if (en_nxt && !en_r) begin
      fbsel_nxt = FBSEL_RST;
      fn2_nxt = FN2_PROCESS;
      fn3_nxt = FN3_MANAUTO;
      fwd_nxt = 1'b1;
      jog_nxt = 1'b0;
    end
    // bumpless transfer wins over a keypad write in the same cycle
    if (to_auto && copy_r && !spsrc_r) begin
      spk_nxt = pv_now;
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      {en_r, rev_r, copy_r, spsrc_r, ack_r, jog_r, fwd_r} <= 7'h00;
      {fbsel_r, dp_r, spk_r, rdat_r} <= {FBSEL_RST, DP_RST, 10'h000, 32'h0000_0000};
      {gain_r, offs_r, kp_r, ki_r, kd_r} <= {GAIN_RST, 16'h0000, KP_RST, KI_RST, 16'h0000};
      {min_r, max_r, scale_r, unit_r} <= {16'h0000, SPD_MAX_RST, SCALE_RST, 24'h000000};
      {fn2_r, fn3_r} <= 16'h0000;
    end else begin
      {en_r, rev_r, copy_r, spsrc_r, ack_r, jog_r, fwd_r} <=
        {en_nxt, rev_nxt, copy_nxt, spsrc_nxt, ack_nxt, jog_nxt, fwd_nxt};
      {fbsel_r, dp_r, spk_r, rdat_r} <= {fbsel_nxt, dp_nxt, spk_nxt, rdat_nxt};
      {gain_r, offs_r, kp_r, ki_r, kd_r} <= {gain_nxt, offs_nxt, kp_nxt, ki_nxt, kd_nxt};
      {min_r, max_r, scale_r, unit_r} <= {min_nxt, max_nxt, scale_nxt, unit_nxt};
      {fn2_r, fn3_r} <= {fn2_nxt, fn3_nxt};
    end
  end

  // =====================================================================
  // feedback and setpoint paths
  ppr_fbscale u_fb (
    .raw_i(ain2_r[fbsel_r]),
    .gain_i(gain_r),
    .offset_i(offs_r),
    .pct_o(pv_now)
  );
  ppr_lim_if pid_lim ();
  ppr_lim_if man_lim ();
  ppr_limit u_pid_lim (.lim(pid_lim));
  ppr_limit u_man_lim (.lim(man_lim));

  // =====================================================================
  // regulator loop; the integrator is only touched on update ticks and on the switch to automatic
  logic [19:0] cnt_r, cnt_nxt;
  logic signed [31:0] integ_r, integ_nxt;
  logic signed [11:0] err, err_q_r, err_q_nxt;
  logic hi_r, lo_r, hi_nxt, lo_nxt, tick, hold;
  logic [9:0] sp_now;
  always_comb begin
    tick = cnt_r == 20'(PID_PERIOD - 1);
    cnt_nxt = tick ? 20'h00000 : cnt_r + 20'h00001;
    sp_now = spsrc_r ? ppr_pct(ain2_r[0]) : spk_r;
    err = rev_r ? 12'(pv_now) - 12'(sp_now) : 12'(sp_now) - 12'(pv_now);
    st_nxt = st_r;
    case (st_r)
      ST_OFF: if (en_r) st_nxt = ST_MANUAL;
      ST_MANUAL: begin
        if (!en_r) begin
          st_nxt = ST_OFF;
        end else if (mai2_r && fn3_r == FN3_MANAUTO) begin
          st_nxt = ST_AUTO;
        end
      end
      ST_AUTO: begin
        if (!en_r) begin
          st_nxt = ST_OFF;
        end else if (!mai2_r || fn3_r != FN3_MANAUTO) begin
          st_nxt = ST_MANUAL;
        end
      end
      default: st_nxt = ST_OFF;
    endcase
    to_auto = st_r == ST_MANUAL && st_nxt == ST_AUTO;
    // p, i and d terms share ten fraction bits
    pid_lim.value = (32'($signed({1'b0, kp_r}) * err) + integ_r
                    + 32'($signed({1'b0, kd_r}) * (err - err_q_r))) >>> GAIN_FRAC;
    pid_lim.lo = min_r;
    pid_lim.hi = max_r;
    man_lim.value = $signed({16'h0000, manual_speed_ref_i});
    man_lim.lo = min_r;
    man_lim.hi = max_r;
    hold = (hi_r && err > 0) || (lo_r && err < 0);
    integ_nxt = integ_r;
    err_q_nxt = err_q_r;
    hi_nxt = hi_r;
    lo_nxt = lo_r;
    spd_nxt = spd_r;
    if (to_auto) begin
      integ_nxt = $signed({6'h00, spd_r, 10'h000}); // start from the running speed
      err_q_nxt = err;
    end else if (st_r == ST_AUTO) begin
      if (tick) begin
        spd_nxt = pid_lim.result;
        hi_nxt = pid_lim.at_hi;
        lo_nxt = pid_lim.at_lo;
        err_q_nxt = err;
        if (!hold) integ_nxt = integ_r + 32'($signed({1'b0, ki_r}) * err);
      end
    end else begin
      spd_nxt = man_lim.result;
      hi_nxt = 1'b0;
      lo_nxt = 1'b0;
    end
    pv_nxt = pv_now;
    sp_nxt = sp_now;
    disp_nxt = 16'((26'(pv_r) * 26'(scale_r)) / PCT_FULL);
  end
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_OFF;
      {cnt_r, integ_r, err_q_r, hi_r, lo_r} <= '0;
      {pv_r, sp_r, spd_r, disp_r} <= '0;
    end else begin
      st_r <= st_nxt;
      {cnt_r, integ_r, err_q_r, hi_r, lo_r} <= {cnt_nxt, integ_nxt, err_q_nxt, hi_nxt, lo_nxt};
      {pv_r, sp_r, spd_r, disp_r} <= {pv_nxt, sp_nxt, spd_nxt, disp_nxt};
    end
  end

  // outputs straight from flops
  assign wb_dat_o = rdat_r;
  assign wb_ack_o = ack_r;
  assign speed_ref_o = spd_r;
  assign auto_mode_o = st_r[2]; // one-hot auto bit, so no gate sits after the flop
  assign forward_only_o = fwd_r;
  assign jog_enable_o = jog_r;

  // =====================================================================
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held over two cycles");
  ack_delay_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  force_cfg_a: assert property ($rose(en_r) |-> fn2_r == FN2_PROCESS && fn3_r == FN3_MANAUTO
    && fbsel_r == FBSEL_RST && forward_only_o && !jog_enable_o) else $error("settings not forced");
  auto_input_a: assert property (st_r == ST_AUTO |-> $past(mai2_r) && fn3_r == FN3_MANAUTO)
    else $error("auto without input high");
  manual_drop_a: assert property (st_r == ST_AUTO && !mai2_r |=> st_r != ST_AUTO)
    else $error("auto kept with input low");
  speed_band_a: assert property ($stable(min_r) && $stable(max_r) && min_r <= max_r
    && $past(st_r) != ST_OFF && st_r != ST_OFF |-> speed_ref_o >= min_r && speed_ref_o <= max_r)
    else $error("speed outside limits");
  auto_copy_a: assert property (to_auto && copy_r && !spsrc_r |=> spk_r == $past(pv_now))
    else $error("setpoint not copied");
  windup_a: assert property (st_r == ST_AUTO && tick && hold && !to_auto |=> $stable(integ_r))
    else $error("integrator moved at limit");
  pv_read_a: assert property (pv_r == $past(pv_now)) else $error("process readout stale");
  auto_c: cover property (to_auto);
  limit_c: cover property (st_r == ST_AUTO && tick && hold);
  copy_c: cover property (to_auto && copy_r && !spsrc_r);
endmodule // ppr_top

// file: tb/ppr_xducer.sv
// process transducer and analog setpoint source in front of the regulator
`timescale 1ns/100ps
module ppr_xducer (
  input wire logic clk_i,
  input wire logic [11:0] pv_target_i,
  input wire logic [11:0] sp_code_i,
  output logic [3:0][11:0] analog_o
);
  // =====================================================================
  // sensor span and lag
  localparam logic [11:0] SPAN_MAX = 12'hE66;
  localparam logic [11:0] SLEW = 12'h040;
  logic [11:0] pv_r = 12'h000;
  logic [11:0] junk_r = 12'hA5A;
  logic [11:0] goal;
  // headroom for overshoot: the sensor signal stays within 90 % of the range
  assign goal = (pv_target_i > SPAN_MAX) ? SPAN_MAX : pv_target_i;
  // the sensor lags the process, so the regulator never sees a step of more than 64 codes per cycle
  always @(posedge clk_i) begin
    if (goal > pv_r + SLEW) begin
      pv_r <= pv_r + SLEW;
    end else if (pv_r > goal + SLEW) begin
      pv_r <= pv_r - SLEW;
    end else begin
      pv_r <= goal;
    end
    junk_r <= ~junk_r; // unused inputs toggle so no stale level looks valid
  end
  // first input carries the analog setpoint, second the process feedback
  assign analog_o = {junk_r, ~junk_r, pv_r, sp_code_i};
endmodule // ppr_xducer

// file: tb/tb.sv
// self-checking bench of the process regulator
`timescale 1ns/100ps
module tb;
  import ppr_pkg::*;
  // =====================================================================
  // signals
  localparam int PER = 8;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [3:0][11:0] analog;
  logic ma = 1'b0;
  logic [15:0] mref = 16'h03E8;
  logic [15:0] spd;
  logic auto_m;
  logic fwd;
  logic jog;
  logic [11:0] pv_tgt = 12'h000;
  logic [11:0] sp_code = 12'h000;
  int error_cnt = 0;
  int num_checks = 0;
  // =====================================================================
  // design and far side
  ppr_top #(.PID_PERIOD(PER)) dut_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .analog_in_i(analog), .manual_auto_input_i(ma),
    .manual_speed_ref_i(mref), .speed_ref_o(spd), .auto_mode_o(auto_m), .forward_only_o(fwd),
    .jog_enable_o(jog));
  ppr_xducer xd_u (.clk_i(clk_sys_i), .pv_target_i(pv_tgt), .sp_code_i(sp_code), .analog_o(analog));
  // =====================================================================
  // helpers
  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one classic cycle; the request stands until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    if (n >= 50) error_cnt++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic end_sim;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // =====================================================================
  // scenarios
  task automatic t_reset;
    chk({spd, auto_m, fwd, jog}, 32'h0);
    rdc(ADR_CTRL, 32'h10);
    rdc(ADR_FB_GAIN, 32'h400);
    rdc(ADR_KI, 32'h400);
    rdc(ADR_KD, 32'h0);
    rdc(ADR_SPD_MAX, 32'h708);
    rdc(ADR_DISP_SCALE, 32'h3E8);
    wr(ADR_PV_READ, 32'hFFFF); // read-only place ignores the write
    rdc(ADR_PV_READ, 32'h0);
    wr(8'h7C, 32'hFFFF);
    rdc(8'h7C, 32'h0);
  endtask
  // the selector input means nothing until the regulator is switched on
  task automatic t_enable;
    @(posedge clk_sys_i);
    ma <= 1'b1;
    cyc(6);
    chk(auto_m, 1'b0);
    wr(ADR_IO_CFG, 32'h0002FFFF);
    wr(ADR_CTRL, 32'h21);
    rdc(ADR_CTRL, 32'h11);
    rdc(ADR_IO_CFG, 32'h00011603);
    chk({fwd, jog}, 2'b10);
    cyc(5);
    chk(auto_m, 1'b1);
    rdc(ADR_STATUS, 32'h4);
    ma <= 1'b0;
    cyc(5);
    chk(auto_m, 1'b0);
    rdc(ADR_STATUS, 32'h2);
  endtask
  // code 2048 is 50.0 %, code 1024 is 25.0 %
  task automatic t_fb;
    @(posedge clk_sys_i);
    pv_tgt <= 12'h800;
    sp_code <= 12'h400;
    cyc(80);
    wr(ADR_CTRL, 32'h19);
    cyc(4);
    rdc(ADR_SP_READ, 32'd250);
    rdc(ADR_PV_READ, 32'd500);
    rdc(ADR_SPD_READ, 32'd1000);
    wr(ADR_FB_GAIN, 32'h600);
    wr(ADR_FB_OFFSET, 32'h10);
    wr(ADR_DISP_SCALE, 32'd250);
    cyc(4);
    rdc(ADR_PV_READ, 32'd766);
    rdc(ADR_DISP_READ, 32'd191);
    wr(ADR_DISP_FMT, 32'h72616201);
    rdc(ADR_DISP_FMT, 32'h72616201);
    wr(ADR_CTRL, 32'h09);
    cyc(4);
    rdc(ADR_PV_READ, 32'd391);
    wr(ADR_FB_GAIN, 32'h400);
    wr(ADR_FB_OFFSET, 32'h0);
    wr(ADR_CTRL, 32'h11);
  endtask
  task automatic t_limit;
    @(posedge clk_sys_i);
    mref <= 16'd3000;
    cyc(3);
    chk(spd, 16'd1800);
    wr(ADR_SPD_MIN, 32'd100);
    mref <= 16'd50;
    cyc(3);
    chk(spd, 16'd100);
    wr(ADR_SPD_MIN, 32'd0);
    mref <= 16'd1000;
    cyc(3);
  endtask
  // keypad entry: 10 of 25 full scale at feedback gain 2 is 80.0 %
  task automatic t_auto;
    wr(ADR_KI, 32'h0);
    wr(ADR_SETPOINT, 32'd10 * 32'd2 * 32'd1000 / 32'd25);
    for (int rev = 0; rev < 2; rev++) begin
      wr(ADR_CTRL, 32'h11 | (rev << CTRL_REV));
      ma <= 1'b1;
      cyc(5 + 4 * PER);
      chk(spd, (rev == 0) ? 16'd1300 : 16'd700);
      ma <= 1'b0;
      cyc(5);
      chk(spd, 16'd1000);
    end
  endtask
  task automatic t_copy;
    wr(ADR_SETPOINT, 32'h3FF);
    rdc(ADR_SETPOINT, 32'd1000);
    wr(ADR_CTRL, 32'h15);
    ma <= 1'b1;
    cyc(5 + 3 * PER);
    rdc(ADR_SETPOINT, 32'd500);
    chk(spd, 16'd1000);
    // a setpoint step shows the derivative term once, on the first tick after it
    wr(ADR_KD, 32'h400);
    wr(ADR_SETPOINT, 32'd600);
    cyc(PER);
    chk(spd, 16'd1200);
    cyc(PER);
    chk(spd, 16'd1100);
    wr(ADR_KD, 32'h0);
    ma <= 1'b0;
    cyc(5);
  endtask
  // a wound-up integral would hold the demand at the limit long after the error turns
  task automatic t_windup;
    wr(ADR_CTRL, 32'h11);
    wr(ADR_KI, 32'h400);
    wr(ADR_SETPOINT, 32'd800);
    ma <= 1'b1;
    cyc(30 * PER);
    chk(spd, 16'd1800);
    wr(ADR_SETPOINT, 32'd0);
    cyc(3 * PER + 4);
    chk(spd < 16'd1800, 1'b1);
    ma <= 1'b0;
  endtask
  // =====================================================================
  // main sequence and watchdog
  initial begin
    cyc(6);
    reset_n_i <= 1'b1;
    cyc(3);
    t_reset();
    t_enable();
    t_fb();
    t_limit();
    t_auto();
    t_copy();
    t_windup();
    end_sim();
  end
  initial begin
    cyc(20000);
    error_cnt++;
    end_sim();
  end
endmodule // tb
